// ---- bench/watchdog_timer_two_stage_bench.sv ----
// Self-checking bench for the two-stage watchdog
`timescale 1ns/10ps
module watchdog_timer_two_stage_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;
    logic        reset_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        debug_halt;
    logic        irq;
    logic        nmi;
    logic        sys_reset;
    logic [2:0]  outs;
    int          err_count;
    int          num_checks;
    int          rst_seen;
    int          r0;
    int          seed;
    int          n;
    logic [31:0] rd;
    logic [31:0] v0;
    logic [31:0] lv;

    assign outs = {sys_reset, nmi, irq};

    wdt_top i_dut (
        .clk             (clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .debug_halt      (debug_halt),
        .irq             (irq),
        .nmi             (nmi),
        .sys_reset       (sys_reset)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and reset pulse counter
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up;
    end
    always @(posedge clk) begin
        if (sys_reset === 1'b1) rst_seen++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Masked status is the raw status gated by the mask
    function automatic logic [31:0] exp_masked(input logic [31:0] raw, input logic [31:0] msk);
        return raw & msk;
    endfunction
    task automatic check_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    // Request held until waitrequest is sampled low; no cycle count assumed
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] data);
        @(posedge clk);
        avs_address    <= {idx, 2'b00};
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        data = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic reg_wr(input logic [2:0] idx, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, idx, d, 4'hf, junk);
    endtask
    task automatic reg_rd(input logic [2:0] idx, output logic [31:0] d);
        bus(1'b0, idx, 32'h0, 4'hf, d);
    endtask
    task automatic wait_out(input int idx, input int lim, output int cnt);
        cnt = 0;
        while (outs[idx] !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 30;
        err_count = 0;
        num_checks = 0;
        rst_seen = 0;
        reset_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        debug_halt = 1'b0;
        do_reset;
        reg_rd(wdt_pkg::REG_LOAD, rd); check(rd, wdt_pkg::LOAD_RESET);
        reg_rd(wdt_pkg::REG_CTRL, rd); check(rd, 32'h0);
        reg_rd(wdt_pkg::REG_ISTAT, rd); check(rd, 32'h0);
        reg_rd(wdt_pkg::REG_LOCK, rd); check(rd, 32'h0);
        check({29'h0, outs}, 32'h0);
        // Partial byte enables must leave the reload untouched
        bus(1'b1, wdt_pkg::REG_LOAD, 32'h10, 4'h3, rd);
        reg_rd(wdt_pkg::REG_LOAD, rd); check(rd, wdt_pkg::LOAD_RESET);
        // Enable first: a reload written while idle need not reach the counter
        reg_wr(wdt_pkg::REG_CTRL, 32'h3);
        reg_rd(wdt_pkg::REG_ISTAT, rd); check(rd, 32'h1);
        reg_wr(wdt_pkg::REG_LOAD, 32'd40);
        reg_rd(wdt_pkg::REG_VALUE, rd); check_rng(rd, 32'd34, 32'd40);
        wait_out(0, 80, n); check(irq, 1'b1);
        reg_rd(wdt_pkg::REG_VALUE, rd); check_rng(rd, 32'd30, 32'd40);
        reg_rd(wdt_pkg::REG_RIS, rd); check(rd[0], 1'b1);
        reg_rd(wdt_pkg::REG_MIS, rd); check(rd[0], 1'b1);
        check(nmi, 1'b0);
        reg_wr(wdt_pkg::REG_ICLR, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wait_out(0, 80, n); check(irq, 1'b1);
        check(rst_seen, 0);
        wait_out(2, 80, n); check(sys_reset, 1'b1);
        reg_wr(wdt_pkg::REG_ICLR, 32'h3);
        lv = 32'd1000 + ($unsigned($random(seed)) % 1000);
        reg_wr(wdt_pkg::REG_LOAD, lv);
        reg_rd(wdt_pkg::REG_VALUE, rd); check_rng(rd, lv - 32'd10, lv);
        reg_rd(wdt_pkg::REG_VALUE, v0); check_rng(v0, rd - 32'd10, rd - 32'd1);
        // Reset disabled: pending timeout plus zero reload gives no reset
        reg_wr(wdt_pkg::REG_CTRL, 32'h1);
        r0 = rst_seen;
        reg_wr(wdt_pkg::REG_LOAD, 32'h0);
        wait_out(0, 5, n); check(irq, 1'b1);
        repeat (20) @(posedge clk);
        check(rst_seen, r0);
        reg_wr(wdt_pkg::REG_LOAD, 32'd1000);
        reg_wr(wdt_pkg::REG_ICLR, 32'h3);
        reg_wr(wdt_pkg::REG_CTRL, 32'h5);
        reg_wr(wdt_pkg::REG_LOAD, 32'd20);
        wait_out(1, 60, n); check(nmi, 1'b1);
        check(irq, 1'b0);
        reg_wr(wdt_pkg::REG_ICLR, 32'h1);
        repeat (2) @(posedge clk);
        check(nmi, 1'b0);
        reg_wr(wdt_pkg::REG_MIS, 32'h0);
        repeat (30) @(posedge clk);
        reg_rd(wdt_pkg::REG_RIS, v0); check(v0[0], 1'b1);
        reg_rd(wdt_pkg::REG_MIS, rd); check(rd[0], 1'b0);
        check(rd, exp_masked(v0, 32'h0));
        check(nmi, 1'b0);
        // Locked: every configuration write except to the lock register is dropped
        reg_wr(wdt_pkg::REG_LOCK, 32'h0);
        reg_rd(wdt_pkg::REG_LOCK, rd); check(rd, 32'h1);
        reg_rd(wdt_pkg::REG_LOAD, v0);
        reg_wr(wdt_pkg::REG_LOAD, $random(seed));
        reg_rd(wdt_pkg::REG_LOAD, rd); check(rd, v0);
        reg_rd(wdt_pkg::REG_CTRL, v0);
        reg_wr(wdt_pkg::REG_CTRL, 32'h2);
        reg_rd(wdt_pkg::REG_CTRL, rd); check(rd, v0);
        reg_wr(wdt_pkg::REG_ICLR, 32'h1);
        reg_rd(wdt_pkg::REG_RIS, rd); check(rd[0], 1'b1);
        reg_wr(wdt_pkg::REG_LOCK, wdt_pkg::UNLOCK_KEY);
        reg_rd(wdt_pkg::REG_LOCK, rd); check(rd, 32'h0);
        // Stall on debug halt, then no stall with halt still high
        reg_wr(wdt_pkg::REG_CTRL, 32'h9);
        reg_wr(wdt_pkg::REG_LOAD, 32'd5000);
        debug_halt <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(wdt_pkg::REG_VALUE, v0);
        repeat (10) @(posedge clk);
        reg_rd(wdt_pkg::REG_VALUE, rd); check(rd, v0);
        reg_wr(wdt_pkg::REG_CTRL, 32'h1);
        reg_rd(wdt_pkg::REG_VALUE, v0);
        reg_rd(wdt_pkg::REG_VALUE, rd); check_rng(rd, v0 - 32'd10, v0 - 32'd1);
        debug_halt <= 1'b0;
        // Second reset, then enable attempt while locked
        do_reset;
        check({29'h0, outs}, 32'h0);
        reg_wr(wdt_pkg::REG_LOCK, 32'h0);
        reg_wr(wdt_pkg::REG_CTRL, 32'h1);
        reg_rd(wdt_pkg::REG_CTRL, rd); check(rd, 32'h0);
        reg_rd(wdt_pkg::REG_ISTAT, rd); check(rd, 32'h0);
        reg_rd(wdt_pkg::REG_VALUE, v0);
        repeat (10) @(posedge clk);
        reg_rd(wdt_pkg::REG_VALUE, rd); check(rd, v0);
        wrap_up;
    end
endmodule // watchdog_timer_two_stage_bench

// ---- rtl/wdt_counter.sv ----
// Watchdog 32-bit down counter with reload and stall
`timescale 1ns/10ps
module wdt_counter (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        run,
    input  wire logic        stall,
    input  wire logic        load_now,
    input  wire logic [31:0] load_value,
    output logic      [31:0] count,
    output logic             zero_hit
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count    <= wdt_pkg::LOAD_RESET;
            zero_hit <= 1'b0;
        end else if (load_now) begin
            count    <= load_value;
            zero_hit <= 1'b0;
        end else if (run && !stall) begin
            if (count == 32'h0000_0000) begin
                count    <= load_value;
                zero_hit <= 1'b1;
            end else begin
                count    <= count - 32'h0000_0001;
                zero_hit <= 1'b0;
            end
        end else begin
            zero_hit <= 1'b0;
        end
    end
endmodule // wdt_counter

// ---- rtl/wdt_pkg.sv ----
// Package of register map, field positions and reset values for the watchdog
package wdt_pkg;
    // ------------------------------------------------------------
    // Register offsets (word indices, word index = addr[4:2])
    // ------------------------------------------------------------
    localparam logic [2:0] REG_LOAD   = 3'h0;
    localparam logic [2:0] REG_VALUE  = 3'h1;
    localparam logic [2:0] REG_CTRL   = 3'h2;
    localparam logic [2:0] REG_ICLR   = 3'h3;
    localparam logic [2:0] REG_RIS    = 3'h4;
    localparam logic [2:0] REG_MIS    = 3'h5;
    localparam logic [2:0] REG_LOCK   = 3'h6;
    localparam logic [2:0] REG_ISTAT  = 3'h7;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_INTEN  = 0;
    localparam int CTRL_RESEN  = 1;
    localparam int CTRL_INTTYP = 2;
    localparam int CTRL_STALL  = 3;
    // ------------------------------------------------------------
    // Status fields (sticky, write one to clear)
    // ------------------------------------------------------------
    localparam int ST_TIMEOUT  = 0;
    localparam int ST_RESET    = 1;
    localparam int ST_WIDTH    = 2;
    // ------------------------------------------------------------
    // Keys and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] UNLOCK_KEY  = 32'h1acc_e551;
    localparam logic [31:0] LOAD_RESET  = 32'hffff_ffff;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ---- rtl/wdt_sync2.sv ----
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/10ps
module wdt_sync2 (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // wdt_sync2

// ---- rtl/wdt_top.sv ----
// Two-stage watchdog timer with Avalon-MM register slave
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module wdt_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        debug_halt,
    output logic             irq,
    output logic             nmi,
    output logic             sys_reset
);
    // ------------------------------------------------------------
    // Bus access decode
    // ------------------------------------------------------------
    logic        ack_reg;
    logic [31:0] load_reg;
    logic [3:0]  ctrl_reg;
    logic        lock_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic        halt_sync;
    logic [31:0] count;
    logic        zero_hit;
    logic        wr_go;
    logic        rd_go;
    logic [2:0]  idx;
    logic        full_word;

    // One wait state per access keeps readdata registered
    assign wr_go     = avs_write && !ack_reg;
    assign rd_go     = avs_read && !ack_reg;
    assign idx       = avs_address[4:2];
    assign full_word = (avs_byteenable == 4'hf);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // ------------------------------------------------------------
    // Debug halt input
    // ------------------------------------------------------------
    wdt_sync2 u_halt_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (debug_halt),
        .q       (halt_sync)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic cfg_wr;
    logic en_wr;
    assign cfg_wr = wr_go && full_word && !lock_reg;
    // One enable write starts the count and arms the timeout interrupt
    assign en_wr  = cfg_wr && idx == wdt_pkg::REG_CTRL
                    && avs_writedata[wdt_pkg::CTRL_INTEN];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= 4'h0;
        end else if (cfg_wr && idx == wdt_pkg::REG_CTRL) begin
            // Enable is sticky: once running only reset stops it
            ctrl_reg[wdt_pkg::CTRL_INTEN] <= ctrl_reg[wdt_pkg::CTRL_INTEN]
                                           | avs_writedata[wdt_pkg::CTRL_INTEN];
            ctrl_reg[wdt_pkg::CTRL_RESEN]  <= avs_writedata[wdt_pkg::CTRL_RESEN];
            ctrl_reg[wdt_pkg::CTRL_INTTYP] <= avs_writedata[wdt_pkg::CTRL_INTTYP];
            ctrl_reg[wdt_pkg::CTRL_STALL]  <= avs_writedata[wdt_pkg::CTRL_STALL];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_reg <= wdt_pkg::LOAD_RESET;
        end else if (cfg_wr && idx == wdt_pkg::REG_LOAD) begin
            load_reg <= avs_writedata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_reg <= 2'h0;
        end else if (cfg_wr && idx == wdt_pkg::REG_MIS) begin
            mask_reg <= avs_writedata[wdt_pkg::ST_WIDTH-1:0];
        end else if (en_wr) begin
            mask_reg[wdt_pkg::ST_TIMEOUT] <= 1'b1;
        end
    end

    // Lock register stays writable; any value but the key locks
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lock_reg <= 1'b0;
        end else if (wr_go && full_word && idx == wdt_pkg::REG_LOCK) begin
            lock_reg <= (avs_writedata != wdt_pkg::UNLOCK_KEY);
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic running;
    logic load_now;
    logic icl_wr;
    assign running  = ctrl_reg[wdt_pkg::CTRL_INTEN];
    assign icl_wr   = wr_go && full_word && !lock_reg && idx == wdt_pkg::REG_ICLR;
    // Reload on new load value or on interrupt clear
    assign load_now = running && (cfg_wr && idx == wdt_pkg::REG_LOAD || icl_wr);

    wdt_counter u_counter (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (running),
        .stall      (ctrl_reg[wdt_pkg::CTRL_STALL] && halt_sync),
        .load_now   (load_now),
        .load_value (cfg_wr && idx == wdt_pkg::REG_LOAD ? avs_writedata : load_reg),
        .count      (count),
        .zero_hit   (zero_hit)
    );

    // ------------------------------------------------------------
    // Interrupt and reset status
    // ------------------------------------------------------------
    logic zero_load;
    logic timeout_set;
    logic second_hit;
    assign zero_load   = running && cfg_wr && idx == wdt_pkg::REG_LOAD
                         && avs_writedata == 32'h0000_0000;
    assign timeout_set = zero_hit || zero_load;
    assign second_hit  = zero_hit && status_reg[wdt_pkg::ST_TIMEOUT]
                         && ctrl_reg[wdt_pkg::CTRL_RESEN];

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
        end else begin
            status_reg[wdt_pkg::ST_TIMEOUT] <= timeout_set
                || (status_reg[wdt_pkg::ST_TIMEOUT]
                    && !(icl_wr && avs_writedata[wdt_pkg::ST_TIMEOUT]));
            status_reg[wdt_pkg::ST_RESET] <= second_hit
                || (status_reg[wdt_pkg::ST_RESET]
                    && !(icl_wr && avs_writedata[wdt_pkg::ST_RESET]));
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= second_hit;
        end
    end

    logic [1:0] masked;
    assign masked = status_reg & mask_reg;

    // Timeout bit routes to nmi or irq; reset event always on irq
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
            nmi <= 1'b0;
        end else begin
            nmi <= masked[wdt_pkg::ST_TIMEOUT] && ctrl_reg[wdt_pkg::CTRL_INTTYP];
            irq <= (masked[wdt_pkg::ST_TIMEOUT] && !ctrl_reg[wdt_pkg::CTRL_INTTYP])
                   || masked[wdt_pkg::ST_RESET];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_readdata <= wdt_pkg::RD_UNMAPPED;
        end else if (rd_go) begin
            unique case (idx)
                wdt_pkg::REG_LOAD:  avs_readdata <= load_reg;
                wdt_pkg::REG_VALUE: avs_readdata <= count;
                wdt_pkg::REG_CTRL:  avs_readdata <= {28'h0, ctrl_reg};
                wdt_pkg::REG_ICLR:  avs_readdata <= wdt_pkg::RD_UNMAPPED;
                wdt_pkg::REG_RIS:   avs_readdata <= {30'h0, status_reg};
                wdt_pkg::REG_MIS:   avs_readdata <= {30'h0, masked};
                wdt_pkg::REG_LOCK:  avs_readdata <= {31'h0, lock_reg};
                wdt_pkg::REG_ISTAT: avs_readdata <= {30'h0, mask_reg};
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_lock_blocks_enable: assert property (@(posedge clk) disable iff (!reset_n)
        lock_reg && !running |=> !running)
        else $error("enable changed while locked");

    a_lock_blocks_load: assert property (@(posedge clk) disable iff (!reset_n)
        lock_reg |=> $stable(load_reg))
        else $error("load changed while locked");

    a_zero_reloads: assert property (@(posedge clk) disable iff (!reset_n)
        running && !load_now && !(ctrl_reg[3] && halt_sync) && count == 32'h0
        |=> count == $past(load_reg))
        else $error("no reload at zero");

    a_counter_decrements: assert property (@(posedge clk) disable iff (!reset_n)
        running && !load_now && !ctrl_reg[3] && count != 32'h0
        |=> count == $past(count) - 32'h1)
        else $error("counter did not decrement");

    a_stall_holds: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_reg[3] && halt_sync && !load_now |=> $stable(count))
        else $error("counter moved while stalled");

    a_reset_cause: assert property (@(posedge clk) disable iff (!reset_n)
        sys_reset |-> $past(status_reg[0]) && $past(ctrl_reg[1]))
        else $error("reset without pending timeout");

    a_timeout_sets: assert property (@(posedge clk) disable iff (!reset_n)
        zero_hit |=> status_reg[0])
        else $error("timeout flag not set");

    a_clear_drops_irq: assert property (@(posedge clk) disable iff (!reset_n)
        icl_wr && avs_writedata[0] && !timeout_set ##1 !timeout_set
        |=> !status_reg[0] ##1 !nmi && irq == $past(masked[1]))
        else $error("clear did not drop interrupt");

    a_enable_arms_irq: assert property (@(posedge clk) disable iff (!reset_n)
        en_wr |=> running && mask_reg[wdt_pkg::ST_TIMEOUT])
        else $error("enable did not arm interrupt");
endmodule // wdt_top
